// *** hdl/ledfc_hidden_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ledfc_params.svh"
module ledfc_hidden_timer
   import ledfc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Control
   input wire logic start,
   input wire logic [1:0] time_code,
   // Status
   output logic active
);
   ledfc_state_t state;
   logic [7:0] count;
   logic [7:0] div;
   logic tick;
   function automatic logic [7:0] cycles_of(input logic [1:0] code);
      case (code)
         2'h0: cycles_of = `LEDFC_TIME_CODE0;
         2'h1: cycles_of = `LEDFC_TIME_CODE1;
         2'h2: cycles_of = `LEDFC_TIME_CODE2;
         default: cycles_of = `LEDFC_TIME_CODE3;
      endcase
   endfunction : cycles_of
   // Internal oscillator as an enable pulse
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div <= 8'h00;
      end else if ((start && state != LEDFC_RUN) ||
                   (div == `LEDFC_OSC_DIV - 8'h01)) begin
         // Restart the timebase so every run lasts whole ticks
         div <= 8'h00;
      end else begin
         div <= div + 8'h01;
      end
   end
   assign tick = (div == `LEDFC_OSC_DIV - 8'h01);
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state <= LEDFC_IDLE;
         count <= 8'h00;
         active <= 1'b0;
      end else begin
         case (state)
            LEDFC_IDLE: begin
               if (start) begin
                  state <= LEDFC_RUN;
                  count <= cycles_of(time_code);
                  active <= 1'b1;
               end
            end
            LEDFC_RUN: begin
               if (tick) begin
                  if (count == 8'h01) begin
                     state <= LEDFC_DONE;
                     active <= 1'b0;
                  end
                  count <= count - 8'h01;
               end
            end
            LEDFC_DONE: begin
               if (start) begin
                  state <= LEDFC_RUN;
                  count <= cycles_of(time_code);
                  active <= 1'b1;
               end else begin
                  state <= LEDFC_IDLE;
               end
            end
            default: begin
               state <= LEDFC_IDLE;
               active <= 1'b0;
            end
         endcase
      end
   end
endmodule : ledfc_hidden_timer
`default_nettype wire

// *** hdl/ledfc_params.svh ***
`ifndef LEDFC_PARAMS_SVH
`define LEDFC_PARAMS_SVH
`define LEDFC_WORD_W 16
`define LEDFC_RESET_WORD 16'hE67F
`define LEDFC_BRIGHT_MSB 6
`define LEDFC_SEL_LSB 7
`define LEDFC_SEL_MSB 8
`define LEDFC_ROLE_BIT 9
`define LEDFC_THRESH_BIT 10
`define LEDFC_CUR_LSB 11
`define LEDFC_CUR_MSB 12
`define LEDFC_TIME_LSB 13
`define LEDFC_TIME_MSB 14
`define LEDFC_PSAVE_BIT 15
`define LEDFC_NARROW_TAP 7
`define LEDFC_WIDE_TAP 15
`define LEDFC_TIME_CODE0 8'h11
`define LEDFC_TIME_CODE1 8'h21
`define LEDFC_TIME_CODE2 8'h41
`define LEDFC_TIME_CODE3 8'h81
`define LEDFC_OSC_DIV 8'h02
`endif

// *** hdl/ledfc_pkg.sv ***
package ledfc_pkg;
   typedef enum logic [1:0] {
      LEDFC_SEL_NONE = 2'h0,
      LEDFC_SEL_OPEN = 2'h1,
      LEDFC_SEL_SHORT = 2'h2,
      LEDFC_SEL_LEAK = 2'h3
   } ledfc_sel_t;
   typedef enum logic [2:0] {
      LEDFC_IDLE = 3'h1,
      LEDFC_RUN = 3'h2,
      LEDFC_DONE = 3'h4
   } ledfc_state_t;
endpackage : ledfc_pkg

// *** hdl/ledfc_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module ledfc_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Pin and result
   input wire logic pin,
   output logic level,
   output logic rise
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            level <= s3;
         end
      end
   end
   assign rise = (s2 == s3) && s3 && !level;
endmodule : ledfc_sync
`default_nettype wire

// *** hdl/ledfc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ledfc_params.svh"
module ledfc_top
   import ledfc_pkg::*;
(
   // Clock and reset
   input wire logic clock,
   input wire logic reset,
   // Serial link from host
   input wire logic serial_shift_clock,
   input wire logic serial_data_in,
   input wire logic load_strobe,
   input wire logic gate_pin,
   output logic serial_data_out,
   // Status sources
   input wire logic [15:0] open_led_flag,
   input wire logic thermal_error_flag,
   input wire logic [15:0] shorted_led_flag,
   input wire logic thermal_prewarning,
   input wire logic [15:0] leakage_flag,
   input wire logic reference_short_flag,
   // Control outputs
   output logic [15:0] function_control_word,
   output logic [6:0] global_brightness_code,
   output logic [1:0] status_load_select,
   output logic gate_pin_role_select,
   output logic short_threshold_select,
   output logic [1:0] hidden_detect_current,
   output logic [1:0] hidden_detect_time,
   output logic power_save_enable,
   output logic [15:0] output_enable,
   output logic hidden_detect_mode,
   output logic power_save
);
   import ledfc_pkg::*;
   localparam int W = `LEDFC_WORD_W;
   logic sclk_level;
   logic sclk_rise;
   logic din_level;
   logic lat_level;
   logic lat_rise;
   logic gate_level;
   logic [W-1:0] shift_word;
   logic [W-1:0] onoff_word;
   logic narrow_tap;
   logic fc_write;
   logic onoff_write;
   logic hidden_active;
   logic hidden_start;
   ledfc_sync u_sync_sclk (.clock(clock), .reset(reset),
      .pin(serial_shift_clock), .level(sclk_level), .rise(sclk_rise));
   ledfc_sync u_sync_din (.clock(clock), .reset(reset),
      .pin(serial_data_in), .level(din_level), .rise());
   ledfc_sync u_sync_lat (.clock(clock), .reset(reset),
      .pin(load_strobe), .level(lat_level), .rise(lat_rise));
   ledfc_sync u_sync_gate (.clock(clock), .reset(reset),
      .pin(gate_pin), .level(gate_level), .rise());

   assign narrow_tap = !function_control_word[`LEDFC_ROLE_BIT] && !gate_level;
   // Strobe edge with shift clock high writes the control word, except in narrow tap mode
   assign fc_write = lat_rise && sclk_level && !narrow_tap;
   assign onoff_write = lat_rise && !sclk_level;

   function automatic logic [W-1:0] status_word(input logic [1:0] sel,
      input logic [W-1:0] opn, input logic [W-1:0] shr,
      input logic [W-1:0] lek, input logic te, input logic pw,
      input logic rs, input logic [W-1:0] keep);
      case (sel)
         LEDFC_SEL_OPEN: status_word = opn | {{(W-1){1'b0}}, te};
         LEDFC_SEL_SHORT: status_word = shr | {{(W-1){1'b0}}, pw};
         LEDFC_SEL_LEAK: status_word = lek | {{(W-1){1'b0}}, rs};
         default: status_word = keep;
      endcase
   endfunction : status_word

   // Shift register: sampled at shift clock rise
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         shift_word <= '0;
      end else if (onoff_write) begin
         shift_word <= status_word(status_load_select, open_led_flag,
            shorted_led_flag, leakage_flag, thermal_error_flag,
            thermal_prewarning, reference_short_flag, shift_word);
      end else if (sclk_rise) begin
         shift_word <= {shift_word[W-2:0], din_level};
      end
   end

   // Control word: all bits in one edge, shift register left alone
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         function_control_word <= `LEDFC_RESET_WORD;
      end else if (fc_write) begin
         function_control_word <= shift_word;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         onoff_word <= '0;
      end else if (onoff_write) begin
         onoff_word <= shift_word;
      end
   end

   // Field outputs, registered from the control word
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         global_brightness_code <= 7'h7F;
         status_load_select <= 2'h0;
         gate_pin_role_select <= 1'b1;
         short_threshold_select <= 1'b1;
         hidden_detect_current <= 2'h0;
         hidden_detect_time <= 2'h3;
         power_save_enable <= 1'b1;
      end else begin
         global_brightness_code <=
            function_control_word[`LEDFC_BRIGHT_MSB:0];
         status_load_select <=
            function_control_word[`LEDFC_SEL_MSB:`LEDFC_SEL_LSB];
         gate_pin_role_select <=
            function_control_word[`LEDFC_ROLE_BIT];
         short_threshold_select <=
            function_control_word[`LEDFC_THRESH_BIT];
         hidden_detect_current <=
            function_control_word[`LEDFC_CUR_MSB:`LEDFC_CUR_LSB];
         hidden_detect_time <=
            function_control_word[`LEDFC_TIME_MSB:`LEDFC_TIME_LSB];
         power_save_enable <=
            function_control_word[`LEDFC_PSAVE_BIT];
      end
   end

   // Serial output tap
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         serial_data_out <= 1'b0;
      end else if (narrow_tap) begin
         serial_data_out <= shift_word[`LEDFC_NARROW_TAP];
      end else begin
         serial_data_out <= shift_word[`LEDFC_WIDE_TAP];
      end
   end

   // Hidden detection after an on/off write when current is nonzero and no run is active
   assign hidden_start = onoff_write &&
      (function_control_word[`LEDFC_CUR_MSB:`LEDFC_CUR_LSB] != 2'h0);
   ledfc_hidden_timer u_timer (.clock(clock), .reset(reset),
      .start(hidden_start),
      .time_code(function_control_word[`LEDFC_TIME_MSB:`LEDFC_TIME_LSB]),
      .active(hidden_active));

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         output_enable <= '0;
         hidden_detect_mode <= 1'b0;
         power_save <= 1'b0;
      end else begin
         hidden_detect_mode <= hidden_active;
         if (function_control_word[`LEDFC_ROLE_BIT] && gate_level) begin
            output_enable <= '0;
         end else if (hidden_active) begin
            output_enable <= '1;
         end else begin
            output_enable <= onoff_word;
         end
         power_save <= function_control_word[`LEDFC_PSAVE_BIT] &&
            (onoff_word == '0) && !hidden_active;
      end
   end

   chk_fc_capture:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> function_control_word == $past(shift_word))
      else $error("control word not captured");
   chk_shift_kept:
   assert property (@(posedge clock) disable iff (reset)
      fc_write && !sclk_rise |=> shift_word == $past(shift_word))
      else $error("shift register changed on control write");
   chk_narrow_block:
   assert property (@(posedge clock) disable iff (reset)
      lat_rise && narrow_tap |=> $stable(function_control_word))
      else $error("control written in narrow tap mode");
   chk_fields_follow:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> ##1 global_brightness_code == $past(shift_word[6:0], 2))
      else $error("brightness field wrong");
   chk_tap_wide:
   assert property (@(posedge clock) disable iff (reset)
      !narrow_tap |=> serial_data_out == $past(shift_word[15]))
      else $error("wide tap wrong");
   chk_gate_off:
   assert property (@(posedge clock) disable iff (reset)
      function_control_word[9] && gate_level |=> output_enable == '0)
      else $error("outputs not forced off");
   chk_psave_on:
   assert property (@(posedge clock) disable iff (reset)
      function_control_word[15] && onoff_word == '0 && !hidden_active
      |=> power_save)
      else $error("power save not entered");
   chk_psave_off:
   assert property (@(posedge clock) disable iff (reset)
      !function_control_word[15] |=> !power_save)
      else $error("power save entered while disabled");
   chk_onoff_load:
   assert property (@(posedge clock) disable iff (reset)
      onoff_write |=> onoff_word == $past(shift_word))
      else $error("on/off latch not loaded");
   chk_hidden_len:
   assert property (@(posedge clock) disable iff (reset)
      hidden_start && function_control_word[14:13] == 2'h0 && !hidden_active
      |=> hidden_active [*8])
      else $error("hidden detect ended early");
   chk_tap_narrow:
   assert property (@(posedge clock) disable iff (reset)
      narrow_tap |=> serial_data_out == $past(shift_word[7]))
      else $error("narrow tap wrong");
   chk_sel_field:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> ##1 status_load_select == $past(shift_word[8:7], 2))
      else $error("status select field wrong");
   chk_role_field:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> ##1 gate_pin_role_select == $past(shift_word[9], 2))
      else $error("gate role field wrong");
   chk_thresh_field:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> ##1 short_threshold_select == $past(shift_word[10], 2))
      else $error("short threshold field wrong");
   chk_current_field:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> ##1 hidden_detect_current == $past(shift_word[12:11], 2))
      else $error("hidden current field wrong");
   chk_time_field:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> ##1 hidden_detect_time == $past(shift_word[14:13], 2))
      else $error("hidden time field wrong");
   chk_psave_field:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> ##1 power_save_enable == $past(shift_word[15], 2))
      else $error("power save field wrong");
   chk_load_none:
   assert property (@(posedge clock) disable iff (reset)
      onoff_write && status_load_select == LEDFC_SEL_NONE
      |=> shift_word == $past(shift_word))
      else $error("status loaded with none selected");
   chk_load_open:
   assert property (@(posedge clock) disable iff (reset)
      onoff_write && status_load_select == LEDFC_SEL_OPEN
      |=> shift_word == ($past(open_led_flag) |
      {{(W-1){1'b0}}, $past(thermal_error_flag)}))
      else $error("open status not loaded");
   chk_load_short:
   assert property (@(posedge clock) disable iff (reset)
      onoff_write && status_load_select == LEDFC_SEL_SHORT
      |=> shift_word == ($past(shorted_led_flag) |
      {{(W-1){1'b0}}, $past(thermal_prewarning)}))
      else $error("short status not loaded");
   chk_load_leak:
   assert property (@(posedge clock) disable iff (reset)
      onoff_write && status_load_select == LEDFC_SEL_LEAK
      |=> shift_word == ($past(leakage_flag) |
      {{(W-1){1'b0}}, $past(reference_short_flag)}))
      else $error("leakage status not loaded");
   chk_hidden_off:
   assert property (@(posedge clock) disable iff (reset)
      onoff_write && !hidden_active &&
      function_control_word[`LEDFC_CUR_MSB:`LEDFC_CUR_LSB] == 2'h0
      |=> !hidden_active)
      else $error("hidden detect ran with zero current");
   chk_hidden_on:
   assert property (@(posedge clock) disable iff (reset)
      hidden_start && !hidden_active |=> hidden_active)
      else $error("hidden detect not started");
   chk_hidden_all_on:
   assert property (@(posedge clock) disable iff (reset)
      hidden_active && !(function_control_word[9] && gate_level)
      |=> output_enable == '1)
      else $error("outputs not all on in hidden detect");
   chk_outputs_follow:
   assert property (@(posedge clock) disable iff (reset)
      !hidden_active && !(function_control_word[9] && gate_level)
      |=> output_enable == $past(onoff_word))
      else $error("outputs do not follow on/off latch");
   chk_onoff_fc_kept:
   assert property (@(posedge clock) disable iff (reset)
      onoff_write |=> $stable(function_control_word))
      else $error("control word changed on on/off write");
   chk_fc_onoff_kept:
   assert property (@(posedge clock) disable iff (reset)
      fc_write |=> $stable(onoff_word))
      else $error("on/off latch changed on control write");
endmodule : ledfc_top
`default_nettype wire

// *** tb/ledfc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module ledfc_host (
   // Clock
   input wire logic clock,
   // Serial pins toward the driver
   input wire logic serial_data_out,
   output logic serial_shift_clock,
   output logic serial_data_in,
   output logic load_strobe,
   output logic gate_pin
);
   initial begin
      serial_shift_clock = 1'b0;
      serial_data_in = 1'b0;
      load_strobe = 1'b0;
      gate_pin = 1'b1;
   end
   // Half of a 200 ns link period
   task automatic half();
      repeat (4) @(posedge clock);
      #2;
   endtask : half
   task automatic set_gate(input logic v);
      gate_pin = v;
      half();
      half();
   endtask : set_gate
   // Shift a word MSB first, capture what falls out, then strobe it
   task automatic frame(input logic [15:0] word, input logic ctl,
                        output logic [15:0] seen);
      seen = 16'h0000;
      for (int i = 15; i >= 0; i--) begin
         serial_data_in = word[i];
         half();
         seen = {seen[14:0], serial_data_out};
         serial_shift_clock = 1'b1;
         half();
         if (i > 0 || !ctl) serial_shift_clock = 1'b0;
      end
      // Data line is no longer valid once the frame is over
      serial_data_in = ~word[0];
      half();
      load_strobe = 1'b1;
      half();
      half();
      load_strobe = 1'b0;
      serial_shift_clock = 1'b0;
      half();
      half();
   endtask : frame
endmodule : ledfc_host
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ledfc_pkg::*;
   logic clock = 1'b0;
   logic reset = 1'b1;
   wire sclk, sdi, strobe, gate;
   logic [15:0] opn, shr, lek, word, oe, seen, prev;
   logic [15:0] tbl [4];
   logic te, pw, rs, sdo, role, thr, pse, hdm, ps;
   logic [6:0] bright;
   logic [1:0] sel, cur, tim;
   int bad_count = 0;
   int n_checks = 0;
   int hd_cnt = 0;
   always #12.5 clock = ~clock;
   always @(posedge clock) if (hdm === 1'b1) hd_cnt <= hd_cnt + 1;
   ledfc_host ledfc_host_i (.clock(clock), .serial_data_out(sdo),
      .serial_shift_clock(sclk), .serial_data_in(sdi),
      .load_strobe(strobe), .gate_pin(gate));
   ledfc_top ledfc_top_i (.clock(clock), .reset(reset),
      .serial_shift_clock(sclk), .serial_data_in(sdi),
      .load_strobe(strobe), .gate_pin(gate), .serial_data_out(sdo),
      .open_led_flag(opn), .thermal_error_flag(te),
      .shorted_led_flag(shr), .thermal_prewarning(pw),
      .leakage_flag(lek), .reference_short_flag(rs),
      .function_control_word(word), .global_brightness_code(bright),
      .status_load_select(sel), .gate_pin_role_select(role),
      .short_threshold_select(thr), .hidden_detect_current(cur),
      .hidden_detect_time(tim), .power_save_enable(pse),
      .output_enable(oe), .hidden_detect_mode(hdm), .power_save(ps));
   task automatic check(input string what, input logic [15:0] got,
                        input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : close_out
   task automatic settle_hd();
      int n;
      n = 0;
      while (hdm !== 1'b0 && n < 400) begin
         @(posedge clock);
         #2;
         n++;
      end
      if (n >= 400) begin
         bad_count++;
         close_out();
      end
   endtask : settle_hd
   initial begin
      #1ms;
      bad_count++;
      close_out();
   end
   initial begin
      opn = 16'h1357;
      shr = 16'h2468;
      lek = 16'h8ACE;
      te = 1'b0;
      pw = 1'b1;
      rs = 1'b0;
      tbl = '{16'h00F0, 16'h1357, 16'h2469, 16'h8ACE};
      repeat (16) @(posedge clock);
      #2;
      reset = 1'b0;
      repeat (8) @(posedge clock);
      #2;
      check("word", word, 16'hE67F);
      check("fields", {pse, tim, cur, thr, role, sel, bright}, 16'hE67F);
      check("psave", 16'(ps), 16'h1);
      // Clear the role bit so the gate pin selects the tap
      ledfc_host_i.frame(16'h7895, 1'b1, seen);
      check("shift", seen, 16'h0000);
      check("word", word, 16'h7895);
      check("psave", 16'(ps), 16'h0);
      // Narrow tap with gate low refuses control writes
      ledfc_host_i.set_gate(1'b0);
      ledfc_host_i.frame(16'h12B4, 1'b1, seen);
      check("word", word, 16'h7895);
      check("tap7", seen, 16'h9512);
      check("tap7", 16'(sdo), 16'h1);
      ledfc_host_i.set_gate(1'b1);
      check("tap15", 16'(sdo), 16'h0);
      ledfc_host_i.frame(16'h7A95, 1'b1, seen);
      check("shift", seen, 16'h12B4);
      check("word", word, 16'h7A95);
      check("fields", {pse, tim, cur, thr, role, sel, bright}, 16'h7A95);
      check("psave", 16'(ps), 16'h0);
      prev = 16'h7A95;
      // Every status selection, read back through the next frame
      for (int s = 0; s < 4; s++) begin
         ledfc_host_i.frame({7'h01, s[1:0], 7'h7F}, 1'b1, seen);
         check("shift", seen, prev);
         ledfc_host_i.frame(16'h00F0, 1'b0, seen);
         check("blanked", oe, 16'h0000);
         ledfc_host_i.set_gate(1'b0);
         check("outputs", oe, 16'h00F0);
         ledfc_host_i.set_gate(1'b1);
         prev = tbl[s];
      end
      check("hidden", 16'(hd_cnt), 16'h0000);
      // Hidden detection for each time code
      for (int t = 0; t < 4; t++) begin
         ledfc_host_i.frame({1'b0, t[1:0], 13'h087F}, 1'b1, seen);
         check("shift", seen, prev);
         hd_cnt = 0;
         ledfc_host_i.frame(16'h0000, 1'b0, seen);
         settle_hd();
         check("hidden", 16'(hd_cnt), 16'((2 ** (t + 4) + 1) * 2));
         prev = 16'h0000;
      end
      check("psave", 16'(ps), 16'h0);
      ledfc_host_i.frame(16'h827F, 1'b1, seen);
      check("psave", 16'(ps), 16'h1);
      ledfc_host_i.frame(16'h0010, 1'b0, seen);
      check("psave", 16'(ps), 16'h0);
      ledfc_host_i.frame(16'h0000, 1'b0, seen);
      check("psave", 16'(ps), 16'h1);
      close_out();
   end
endmodule : testbench
`default_nettype wire
